/* File: core/adc_extra_conversion_control.sv */
// extra conversion control: axi4-lite register slave plus launch sequencer
// assumes: converter core on aclk reports sequence activity and extra done
`timescale 1ns/1ps
module adc_extra_conversion_control
    import xconv_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [xconv_pkg::ADDR_W-1:0] s_axi_awaddr,
    input wire logic [2:0] s_axi_awprot,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [xconv_pkg::ADDR_W-1:0] s_axi_araddr,
    input wire logic [2:0] s_axi_arprot,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic seq_running,
    input wire logic conv_done,
    output logic extra_start,
    output logic extra_active,
    output logic [3:0] conv_channel,
    output logic [1:0] conv_ref_sel,
    output logic [1:0] conv_decim_sel,
    output logic [9:0] conv_decim_rate,
    output logic [3:0] conv_result_bits,
    output logic [2:0] conv_pos_input,
    output logic [2:0] conv_neg_input,
    output logic conv_differential,
    output logic conv_internal,
    output logic [1:0] conv_internal_sel
);
    import xconv_pkg::*;

    typedef enum logic [1:0] {st_idle, st_wait_seq, st_convert} state_e;

    // ========================================
    // write channel
    logic aw_held;
    logic w_held;
    logic [ADDR_W-1:0] aw_addr;
    logic [7:0] w_byte;
    logic w_lane0;
    logic aw_take;
    logic w_take;
    logic wr_fire;
    logic next_aw_held;
    logic next_w_held;

    assign aw_take = s_axi_awvalid & s_axi_awready;
    assign w_take = s_axi_wvalid & s_axi_wready;
    // one write at a time: fire only once the previous response is gone
    assign wr_fire = aw_held & w_held & ~s_axi_bvalid;
    assign next_aw_held = (aw_held & ~wr_fire) | aw_take;
    assign next_w_held = (w_held & ~wr_fire) | w_take;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
        end else begin
            aw_held <= next_aw_held;
            w_held <= next_w_held;
            s_axi_awready <= ~next_aw_held;
            s_axi_wready <= ~next_w_held;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_addr <= '0;
            w_byte <= 8'h00;
            w_lane0 <= 1'b0;
        end else begin
            if (aw_take) begin
                aw_addr <= s_axi_awaddr;
            end
            if (w_take) begin
                w_byte <= s_axi_wdata[7:0];
                w_lane0 <= s_axi_wstrb[0];
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OKAY;
        end else if (wr_fire) begin
            s_axi_bvalid <= 1'b1;
            // status is read-only, so a write there is refused too
            s_axi_bresp <= (aw_addr == CTRL_ADDR) ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // ========================================
    // control register
    logic [1:0] ref_sel;
    logic [1:0] decim_sel;
    logic [3:0] chan_sel;
    logic ctrl_write;
    logic ch_write;
    logic [1:0] next_ref_sel;
    logic [1:0] next_decim_sel;
    logic [3:0] next_chan_sel;
    state_e state;
    logic armed;
    logic launch;

    // only byte lane 0 carries the 8-bit register
    assign ctrl_write = wr_fire & w_lane0 & (aw_addr == CTRL_ADDR);
    // every accepted control write of lane 0 writes the channel field as well
    assign ch_write = ctrl_write;

    always_comb begin
        next_ref_sel = ref_sel;
        next_decim_sel = decim_sel;
        next_chan_sel = chan_sel;
        if (ctrl_write) begin
            next_ref_sel = w_byte[REF_LSB +: 2];
            next_decim_sel = w_byte[DIV_LSB +: 2];
            next_chan_sel = w_byte[CH_LSB +: 4];
        end else if (state == st_convert && conv_done && !armed) begin
            // write in the done cycle wins; a queued rewrite keeps its channel
            next_chan_sel = CH_RST;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ref_sel <= REF_RST;
            decim_sel <= DIV_RST;
            chan_sel <= CH_RST;
        end else begin
            ref_sel <= next_ref_sel;
            decim_sel <= next_decim_sel;
            chan_sel <= next_chan_sel;
        end
    end

    // ========================================
    // launch sequencer
    state_e next_state;
    logic [3:0] last_channel;

    always_comb begin
        next_state = state;
        launch = 1'b0;
        case (state)
            st_idle: begin
                if (ch_write || armed) begin
                    if (seq_running) begin
                        next_state = st_wait_seq;
                    end else begin
                        launch = 1'b1;
                        next_state = st_convert;
                    end
                end
            end
            st_wait_seq: begin
                // sequence has ended once running drops
                if (!seq_running) begin
                    launch = 1'b1;
                    next_state = st_convert;
                end
            end
            st_convert: begin
                if (conv_done) begin
                    next_state = st_idle;
                end
            end
            default: next_state = st_idle;
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state <= st_idle;
        end else begin
            state <= next_state;
        end
    end

    // a rewrite during a conversion queues one more conversion
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            armed <= 1'b0;
        end else if (ch_write && state == st_convert) begin
            armed <= 1'b1;
        end else if (state == st_idle) begin
            armed <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            last_channel <= CH_RST;
        end else if (state == st_convert && conv_done) begin
            last_channel <= conv_channel;
        end
    end

    // ========================================
    // converter outputs, latched at launch so later writes do not disturb
    logic [2:0] route_pos;
    logic [2:0] route_neg;
    logic route_diff;
    logic route_internal;
    logic [1:0] route_internal_sel;

    extra_conv_route u_route (
        .channel(next_chan_sel),
        .pos_input(route_pos),
        .neg_input(route_neg),
        .differential(route_diff),
        .internal(route_internal),
        .internal_sel(route_internal_sel)
    );

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            extra_start <= 1'b0;
            extra_active <= 1'b0;
        end else begin
            extra_start <= launch;
            extra_active <= (next_state == st_convert);
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            conv_channel <= CH_RST;
            conv_ref_sel <= REF_RST;
            conv_decim_sel <= DIV_RST;
            conv_decim_rate <= decim_rate(DIV_RST);
            conv_result_bits <= result_bits(DIV_RST);
            conv_pos_input <= 3'h0;
            conv_neg_input <= 3'h0;
            conv_differential <= 1'b0;
            conv_internal <= 1'b0;
            conv_internal_sel <= SRC_GND;
        end else if (launch) begin
            conv_channel <= next_chan_sel;
            conv_ref_sel <= next_ref_sel;
            conv_decim_sel <= next_decim_sel;
            conv_decim_rate <= decim_rate(next_decim_sel);
            conv_result_bits <= result_bits(next_decim_sel);
            conv_pos_input <= route_pos;
            conv_neg_input <= route_neg;
            conv_differential <= route_diff;
            conv_internal <= route_internal;
            conv_internal_sel <= route_internal_sel;
        end
    end

    // ========================================
    // read channel
    logic ar_take;
    logic next_rvalid;
    logic [7:0] ctrl_view;
    logic [7:0] status_view;

    assign ar_take = s_axi_arvalid & s_axi_arready;
    assign next_rvalid = (s_axi_rvalid & ~s_axi_rready) | ar_take;
    assign ctrl_view = {ref_sel, decim_sel, chan_sel};

    always_comb begin
        status_view = 8'h00;
        status_view[ST_BUSY] = (state == st_convert);
        status_view[ST_WAIT] = (state == st_wait_seq);
        status_view[ST_ARMED] = armed;
        status_view[ST_LAST_LSB +: 4] = last_channel;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
        end else begin
            s_axi_arready <= ~next_rvalid;
            s_axi_rvalid <= next_rvalid;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= RESP_OKAY;
        end else if (ar_take) begin
            case (s_axi_araddr)
                CTRL_ADDR: begin
                    s_axi_rdata <= {24'h00_0000, ctrl_view};
                    s_axi_rresp <= RESP_OKAY;
                end
                STATUS_ADDR: begin
                    s_axi_rdata <= {24'h00_0000, status_view};
                    s_axi_rresp <= RESP_OKAY;
                end
                default: begin
                    s_axi_rdata <= 32'h0000_0000;
                    s_axi_rresp <= RESP_SLVERR;
                end
            endcase
        end
    end
endmodule : adc_extra_conversion_control

/* File: core/xconv_pkg.sv */
// package: register map, field layout, codes and decode functions
// assumes: one 32-bit axi4-lite register space, word aligned
package xconv_pkg;
    // ========================================
    // register map
    localparam int ADDR_W = 12;
    localparam logic [ADDR_W-1:0] CTRL_INDEX = 12'h0B6;
    localparam logic [ADDR_W-1:0] STATUS_INDEX = 12'h0B7;
    localparam logic [ADDR_W-1:0] CTRL_ADDR = 12'h2D8;
    localparam logic [ADDR_W-1:0] STATUS_ADDR = 12'h2DC;
    // ========================================
    // field layout of the control register
    localparam int REF_LSB = 6;
    localparam int DIV_LSB = 4;
    localparam int CH_LSB = 0;
    localparam logic [1:0] REF_RST = 2'h0;
    localparam logic [1:0] DIV_RST = 2'h0;
    localparam logic [3:0] CH_RST = 4'h0;
    // ========================================
    // field layout of the status register
    localparam int ST_BUSY = 0;
    localparam int ST_WAIT = 1;
    localparam int ST_ARMED = 2;
    localparam int ST_LAST_LSB = 4;
    // ========================================
    // codes
    localparam logic [1:0] REF_INTERNAL = 2'h0;
    localparam logic [1:0] REF_INPUT_SEVEN = 2'h1;
    localparam logic [1:0] REF_SUPPLY_PIN = 2'h2;
    localparam logic [1:0] REF_DIFF_SIX_SEVEN = 2'h3;
    localparam logic [3:0] CH_LAST_SINGLE = 4'h7;
    localparam logic [3:0] CH_LAST_DIFF = 4'hB;
    localparam logic [3:0] CH_GND = 4'hC;
    localparam logic [3:0] CH_POS_REF = 4'hD;
    localparam logic [3:0] CH_TEMP = 4'hE;
    localparam logic [3:0] CH_THIRD_SUPPLY = 4'hF;
    localparam logic [1:0] SRC_GND = 2'h0;
    localparam logic [1:0] SRC_POS_REF = 2'h1;
    localparam logic [1:0] SRC_TEMP = 2'h2;
    localparam logic [1:0] SRC_THIRD_SUPPLY = 2'h3;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    // ========================================
    // decimation rate and resolution per code
    function automatic logic [9:0] decim_rate(input logic [1:0] code);
        case (code)
            2'h0: decim_rate = 10'h040;
            2'h1: decim_rate = 10'h080;
            2'h2: decim_rate = 10'h100;
            default: decim_rate = 10'h200;
        endcase
    endfunction : decim_rate

    function automatic logic [3:0] result_bits(input logic [1:0] code);
        case (code)
            2'h0: result_bits = 4'h7;
            2'h1: result_bits = 4'h9;
            2'h2: result_bits = 4'hA;
            default: result_bits = 4'hC;
        endcase
    endfunction : result_bits
endpackage : xconv_pkg

/* File: core/extra_conv_route.sv */
// leaf: turns a channel code into converter input routing
// assumes: purely combinational, caller registers the outputs
`timescale 1ns/1ps
module extra_conv_route
    import xconv_pkg::*;
(
    input wire logic [3:0] channel,
    output logic [2:0] pos_input,
    output logic [2:0] neg_input,
    output logic differential,
    output logic internal,
    output logic [1:0] internal_sel
);
    always_comb begin
        pos_input = 3'h0;
        neg_input = 3'h0;
        differential = 1'b0;
        internal = 1'b0;
        internal_sel = SRC_GND;
        if (channel <= CH_LAST_SINGLE) begin
            // single-ended inputs zero to seven
            pos_input = channel[2:0];
        end else if (channel <= CH_LAST_DIFF) begin
            // pairs 0-1, 2-3, 4-5, 6-7
            differential = 1'b1;
            pos_input = {channel[1:0], 1'b0};
            neg_input = {channel[1:0], 1'b1};
        end else begin
            internal = 1'b1;
            case (channel)
                CH_GND: internal_sel = SRC_GND;
                CH_POS_REF: internal_sel = SRC_POS_REF;
                CH_TEMP: internal_sel = SRC_TEMP;
                default: internal_sel = SRC_THIRD_SUPPLY;
            endcase
        end
    end
endmodule : extra_conv_route

/* File: tb/adc_extra_conversion_control_props.sv */
// checker: launch and routing relations of the extra conversion control
// assumes: bound to the top module, one clock aclk, synchronous reset
`timescale 1ns/1ps
module adc_extra_conversion_control_props (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic seq_running,
    input wire logic conv_done,
    input wire logic extra_start,
    input wire logic extra_active,
    input wire logic [3:0] conv_channel,
    input wire logic [1:0] conv_ref_sel,
    input wire logic [1:0] conv_decim_sel,
    input wire logic [9:0] conv_decim_rate,
    input wire logic [3:0] conv_result_bits,
    input wire logic [2:0] conv_pos_input,
    input wire logic conv_differential,
    input wire logic conv_internal,
    input wire logic [1:0] conv_internal_sel
);
    // ========================================
    // assertions
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    a_start_pulse: assert property (extra_start |=> !extra_start)
        else $error("start pulse too long");
    a_start_active: assert property (extra_start |-> extra_active)
        else $error("start without active");
    a_seq_wait: assert property (!extra_active && seq_running |=> !extra_start)
        else $error("start during sequence");
    a_done_drop: assert property (extra_active && conv_done |=> !extra_active || extra_start)
        else $error("active after done");
    a_rate_map: assert property (extra_start |-> conv_decim_rate == (10'h040 << conv_decim_sel))
        else $error("wrong decimation rate");
    a_bits_map: assert property (extra_start |-> conv_result_bits == (conv_decim_sel == 2'h0 ? 4'h7 :
        conv_decim_sel == 2'h1 ? 4'h9 : conv_decim_sel == 2'h2 ? 4'hA : 4'hC))
        else $error("wrong resolution");
    a_route_single: assert property (extra_start && conv_channel < 4'h6 |->
        conv_pos_input == conv_channel[2:0] && !conv_differential && !conv_internal)
        else $error("wrong single route");
    a_route_internal: assert property (extra_start && conv_channel > 4'hB |->
        conv_internal && conv_internal_sel == conv_channel[1:0])
        else $error("wrong internal route");
    a_ref_latch: assert property ($changed(conv_ref_sel) |-> extra_start)
        else $error("reference moved off launch");
    // ========================================
    // covers
    c_internal: cover property (extra_start && conv_channel > 4'hB);
    c_done: cover property (extra_active && conv_done);
    c_seq_end: cover property (!extra_active && seq_running ##1 !seq_running);
    c_queued: cover property (extra_active && conv_done ##2 extra_start);
endmodule : adc_extra_conversion_control_props

bind adc_extra_conversion_control adc_extra_conversion_control_props u_props (
    .aclk, .aresetn, .seq_running, .conv_done, .extra_start, .extra_active, .conv_channel,
    .conv_ref_sel, .conv_decim_sel, .conv_decim_rate, .conv_result_bits, .conv_pos_input,
    .conv_differential, .conv_internal, .conv_internal_sel
);

/* File: tb/adc_extra_conversion_control_tb.sv */
// testbench: axi4-lite master, converter stand-in and reference model
// assumes: xconv_pkg compiled first, design ports as declared there
`timescale 1ns/1ps
module adc_extra_conversion_control_tb;
    import xconv_pkg::*;
    logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
    logic s_axi_rready, seq_running, conv_done, extra_start, extra_active;
    logic conv_differential, conv_internal;
    logic [ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
    logic [2:0] s_axi_awprot, s_axi_arprot, conv_pos_input, conv_neg_input;
    logic [31:0] s_axi_wdata, s_axi_rdata, cap, d;
    logic [3:0] s_axi_wstrb, conv_channel, conv_result_bits;
    logic [1:0] s_axi_bresp, s_axi_rresp, conv_ref_sel, conv_decim_sel, conv_internal_sel, r;
    logic [9:0] conv_decim_rate;
    int errors, check_count, n, starts, exp_ctrl;
    int bits_tab[4] = '{7, 9, 10, 12};
    int exp_q[$];

    adc_extra_conversion_control DUT (
        .aclk, .aresetn, .s_axi_awaddr, .s_axi_awprot, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arprot, .s_axi_arvalid, .s_axi_arready,
        .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .seq_running, .conv_done,
        .extra_start, .extra_active, .conv_channel, .conv_ref_sel, .conv_decim_sel,
        .conv_decim_rate, .conv_result_bits, .conv_pos_input, .conv_neg_input,
        .conv_differential, .conv_internal, .conv_internal_sel
    );

    initial begin
        aclk = 0;
        forever #2 aclk = ~aclk;
    end

    // ========================================
    // launch monitor: sampled mid-cycle, so the main thread never races it
    always @(negedge aclk) begin
        if (extra_start === 1'b1) begin
            starts++;
            cap = {conv_channel, conv_ref_sel, conv_decim_sel, conv_decim_rate, conv_result_bits,
                conv_pos_input, conv_neg_input, conv_differential, conv_internal, conv_internal_sel};
            chk(exp_q.size() > 0, 1, "launch not asked for");
            if (exp_q.size() > 0) chk(cap[31:24], exp_q.pop_front(), "model fields");
        end
    end

    // ========================================
    // common tasks
    task tally_and_finish();
        $display("checks %0d mismatches %0d", check_count, errors);
        if (errors == 0 && check_count > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : tally_and_finish

    // every wait after the first cycle out of reset goes through here, so a hang ends the run
    task tick();
        @(posedge aclk);
        n++;
        if (n > 200) begin
            errors++;
            $display("unexpected %0t wait timed out", $time);
            tally_and_finish();
        end
    endtask : tick

    task chk(input logic [31:0] seen, input logic [31:0] exp, input string m);
        check_count++;
        if (seen !== exp) begin
            errors++;
            $display("unexpected %0t %s: %0h not %0h", $time, m, seen, exp);
        end
    endtask : chk

    task wr(input logic [11:0] a, input logic [7:0] v, input logic [3:0] s, output logic [1:0] rs);
        bit aw, w;
        n = 0;
        tick();
        s_axi_awaddr <= a;
        s_axi_wdata <= {24'($urandom), v};
        s_axi_wstrb <= s;
        s_axi_awvalid <= 1;
        s_axi_wvalid <= 1;
        s_axi_bready <= 1;
        aw = 0;
        w = 0;
        while (!(aw && w)) begin
            tick();
            if (s_axi_awready === 1'b1) begin
                aw = 1;
                s_axi_awvalid <= 0;
            end
            if (s_axi_wready === 1'b1) begin
                w = 1;
                s_axi_wvalid <= 0;
            end
        end
        do tick(); while (s_axi_bvalid !== 1'b1);
        rs = s_axi_bresp;
        s_axi_bready <= 0;
    endtask : wr

    task rd(input logic [11:0] a, output logic [31:0] v, output logic [1:0] rs);
        n = 0;
        tick();
        s_axi_araddr <= a;
        s_axi_arvalid <= 1;
        s_axi_rready <= 1;
        do tick(); while (s_axi_arready !== 1'b1);
        s_axi_arvalid <= 0;
        do tick(); while (s_axi_rvalid !== 1'b1);
        v = s_axi_rdata;
        rs = s_axi_rresp;
        s_axi_rready <= 0;
    endtask : rd

    // one extra conversion; hold > 0 keeps a sequence running that long
    task launch(input int ch, input int rf, input int dv, input int hold);
        int s0;
        exp_ctrl = rf * 64 + dv * 16 + ch;
        s0 = starts;
        seq_running <= (hold > 0);
        exp_q.push_back(ch * 16 + rf * 4 + dv);
        wr(CTRL_ADDR, 8'(exp_ctrl), {3'($urandom), 1'b1}, r);
        chk(r, RESP_OKAY, "write resp");
        repeat (hold) tick();
        chk(starts, s0 + (hold == 0), "start before sequence end");
        seq_running <= 0;
        n = 0;
        while (starts == s0) tick();
        chk(cap[31:24], ch * 16 + rf * 4 + dv, "launch fields");
        chk(cap[23:14], 64 << dv, "decimation rate");
        chk(cap[13:10], bits_tab[dv], "resolution");
        chk(cap[2], ch >= 12, "internal route");
        if (ch >= 12) chk(cap[1:0], ch - 12, "internal source");
        else if (ch >= 8) chk(cap[9:3], {3'(2 * ch - 16), 3'(2 * ch - 15), 1'b1}, "pair");
        else chk({cap[9:7], cap[3]}, ch * 2, "single route");
        rd(CTRL_ADDR, d, r);
        chk(d, exp_ctrl, "ctrl while active");
        conv_done <= 1;
        tick();
        conv_done <= 0;
        tick();
        tick();
        chk(extra_active, 0, "active after done");
        exp_ctrl = exp_ctrl & 8'hF0;
        rd(CTRL_ADDR, d, r);
        chk(d, exp_ctrl, "channel clear");
        chk(starts, s0 + 1, "single launch");
    endtask : launch

    // ========================================
    // main sequence
    initial begin
        {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid} = '0;
        {s_axi_rready, seq_running, conv_done, s_axi_awaddr, s_axi_araddr} = '0;
        {s_axi_awprot, s_axi_arprot, s_axi_wdata, s_axi_wstrb} = '0;
        void'($urandom(32'h15B6));
        repeat (20) @(posedge aclk);
        aresetn <= 1;
        @(posedge aclk);
        chk(conv_decim_rate, 64, "reset rate");
        rd(CTRL_ADDR, d, r);
        chk(d, 0, "reset value");
        $display("test reset done");
        // every channel, reference and decimation code; odd ones wait on a sequence
        for (int i = 0; i < 16; i++) launch(i, i % 4, i / 4, (i % 2) ? 2 + $urandom % 8 : 0);
        $display("test launches done");
        wr(CTRL_ADDR, 8'h35, 4'hE, r);
        chk(r, RESP_OKAY, "masked write resp");
        repeat (8) tick();
        chk(starts, 16, "masked write started");
        rd(CTRL_ADDR, d, r);
        chk(d, exp_ctrl, "masked write landed");
        wr(STATUS_ADDR, 8'h07, 4'hF, r);
        chk(r, RESP_SLVERR, "status write resp");
        chk(starts, 16, "status write started");
        rd(12'h100, d, r);
        chk(r, RESP_SLVERR, "unmapped resp");
        chk(d, 0, "unmapped data");
        $display("test refusals done");
        // a rewrite while converting queues exactly one more launch
        exp_q.push_back(8'h36);
        exp_q.push_back(8'hA6);
        wr(CTRL_ADDR, 8'h63, 4'h1, r);
        wr(CTRL_ADDR, 8'h6A, 4'h1, r);
        chk(starts, 17, "rewrite started");
        rd(STATUS_ADDR, d, r);
        chk(d, 1 << ST_BUSY | 1 << ST_ARMED | 15 << ST_LAST_LSB, "status queued");
        conv_done <= 1;
        tick();
        conv_done <= 0;
        n = 0;
        while (starts < 18) tick();
        chk(cap[31:24], 8'hA6, "queued fields");
        conv_done <= 1;
        tick();
        conv_done <= 0;
        repeat (4) tick();
        rd(STATUS_ADDR, d, r);
        chk(d, 10 << ST_LAST_LSB, "status idle");
        rd(CTRL_ADDR, d, r);
        chk(d, 8'h60, "queued clear");
        chk(starts, 18, "one queued launch");
        $display("test rewrite done");
        tally_and_finish();
    end
endmodule : adc_extra_conversion_control_tb
